// ==== hdl/aap_pkg.sv ====
/*
 Constants for the arming and PCM output block: pin field encodings,
 SPI frame layout, timing counts and per-axis limits.
 Assumes a 100 MHz system clock and an external SPI master.
*/
// Behaviour
// - Count mode: sample meeting either threshold increments the axis counter.
// - Count mode: sample strictly inside both thresholds clears the counter.
// - One new sample per axis at the closing chip-select edge of a request.
// - Counter reaching window limit flags arming, asserts output, loads stretch.
// - Count mode with stretch: output releases only when stretch expires.
// - Unfiltered: at request end, compare latest sample; either threshold arms.
// - Unfiltered: output active while selected and frame carries that axis reply.
// - No stretching ever in unfiltered mode.
// - Stretch setting 00: output follows last evaluated arming condition.
// - Stretch setting non-zero: output active exactly while timer non-zero.
// - Stretch timer counts down continuously and holds at zero.
// - Stretch timer reloads only when last evaluated sample armed.
// - Separate two-bit stretch setting per axis.
// - During an exception stretch runs out; new reads never reload it.
// - Arming pins are active high or active low per configuration field.
// - PCM selection turns both axis pins into PCM digital outputs.
// - PCM input saturates to nine bits, offset to unsigned 0..511.
// - PCM accumulator adds the value every 8 MHz cycle.
// - PCM pin carries each accumulation's carry-out.
// - X block takes X requests and even registers, Y odd and Y requests; code queues every register op, even or odd, in one FIFO.
// - Shift register mismatch: Y silent, X replies with an error word.
// - On match only the addressed block drives the reply next frame.
// - Window change needs arming disabled (000) first, then re-enabled.
// - Per-axis eight-bit positive and negative thresholds.
// - Sample latched at request end is shifted out in the next frame.
// - SPI mode 0, most significant bit first, device is slave.
package aap_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int PCM_HZ = 8_000_000;
	localparam int NCO_UNIT_HZ = 1_000_000;
	localparam logic [6:0] PCM_NCO_STEP = 7'(PCM_HZ / NCO_UNIT_HZ);
	localparam logic [6:0] PCM_NCO_MOD = 7'(CLK_HZ / NCO_UNIT_HZ);
	localparam int STRETCH_UNIT_US = 1000;
	localparam int STRETCH_UNIT_CYC = STRETCH_UNIT_US * (CLK_HZ / 1_000_000);

	localparam int SAMPLE_W = 12;
	localparam int THR_W = 8;
	localparam int PCM_W = 9;
	localparam int CNT_W = 4;
	localparam int STR_W = 20;
	localparam int FRAME_W = 16;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 16;

	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_MAVG = 3'h1;
	localparam logic [2:0] MODE_CNT_HI = 3'h2;
	localparam logic [2:0] MODE_CNT_LO = 3'h3;
	localparam logic [2:0] MODE_UNF_HI = 3'h4;
	localparam logic [2:0] MODE_UNF_LO = 3'h5;
	localparam logic [2:0] MODE_PCM = 3'h6;

	localparam logic [CNT_W-1:0] WIN_LIMIT [0:3] = '{4'h1, 4'h2, 4'h4, 4'h8};

	localparam int CMD_AX_BIT = 14;
	localparam int CMD_A_BIT = 13;
	localparam int CMD_ADDR_LSB = 8;
	localparam logic [1:0] RESP_ACC_TAG = 2'h1;
	localparam logic [FRAME_W-1:0] ERR_WORD = 16'hFFFF;

	localparam logic signed [PCM_W:0] PCM_SMAX = 10'sh0FF;
	localparam logic signed [PCM_W:0] PCM_SMIN = -10'sh100;
	localparam logic [PCM_W-1:0] PCM_MID = 9'h100;
endpackage

// ==== hdl/aap_top.sv ====
/*
 Dual-axis arming logic, PCM bitstream outputs, dual SPI slave front end
 and a command FIFO toward register logic.
 Assumes samples and configuration come from logic on clk_i; the SPI pins
 are asynchronous and are synchronised here. SPI clock is slow enough to
 give at least four system cycles per half period.
*/
module aap_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	// Pointers wrap by overflow, so D must be a power of two
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} aap_fifo_st_t;

	aap_fifo_st_t r;
	aap_fifo_st_t n;
	logic push;
	logic pop;

	assign in_ready_o = r.cnt != (AW+1)'(D);
	assign out_valid_o = r.cnt != '0;
	assign out_data_o = r.mem[r.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb
	begin
		n = r;
		if (push)
		begin
			n.mem[r.wp] = in_data_i;
			n.wp = r.wp + 1'b1;
		end
		if (pop)
			n.rp = r.rp + 1'b1;
		if (push && !pop)
			n.cnt = r.cnt + 1'b1;
		else if (pop && !push)
			n.cnt = r.cnt - 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			r <= '0;
		else
			r <= n;
	end
endmodule

module aap_top #(
	parameter int STRETCH_UNIT_CYC_P = aap_pkg::STRETCH_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic [2:0] arming_config_i,
	input wire logic [aap_pkg::THR_W-1:0] x_arm_threshold_pos_i,
	input wire logic [aap_pkg::THR_W-1:0] x_arm_threshold_neg_i,
	input wire logic [aap_pkg::THR_W-1:0] y_arm_threshold_pos_i,
	input wire logic [aap_pkg::THR_W-1:0] y_arm_threshold_neg_i,
	input wire logic [1:0] x_window_size_i,
	input wire logic [1:0] y_window_size_i,
	input wire logic [1:0] x_stretch_setting_i,
	input wire logic [1:0] y_stretch_setting_i,
	input wire logic exception_i,
	input wire logic [aap_pkg::SAMPLE_W-1:0] x_sample_i,
	input wire logic [aap_pkg::SAMPLE_W-1:0] y_sample_i,
	output logic x_arm_pin_o,
	output logic y_arm_pin_o,
	output logic arm_pin_oe_o,
	output logic [aap_pkg::FIFO_W-1:0] reg_cmd_o,
	output logic reg_cmd_valid_o,
	input wire logic reg_cmd_ready_i
);
	import aap_pkg::*;

	typedef struct packed {
		logic csa_m;
		logic csa_s;
		logic csa_d;
		logic sclk_m;
		logic sclk_s;
		logic sclk_d;
		logic mosi_m;
		logic mosi_s;
		logic [FRAME_W-1:0] sh_x;
		logic [FRAME_W-1:0] sh_y;
		logic [4:0] bitcnt;
		logic [FRAME_W-1:0] tx;
		logic tx_en;
		logic [FRAME_W-1:0] next_word;
		logic next_en;
		logic [1:0] next_acc;
		logic [1:0] cur_acc;
		logic [1:0][CNT_W-1:0] cnt;
		logic [1:0] cond;
		logic [1:0][STR_W-1:0] str;
		logic [6:0] nco;
		logic [1:0][PCM_W-1:0] acc;
		logic [1:0] pin;
		logic pin_oe;
		logic miso;
		logic miso_oe;
	} aap_st_t;

	aap_st_t r;
	aap_st_t n;
	logic fifo_push;
	logic fifo_in_ready;
	logic [FRAME_W-1:0] fifo_word;

	assign spi_miso_o = r.miso;
	assign spi_miso_oe_o = r.miso_oe;
	assign x_arm_pin_o = r.pin[0];
	assign y_arm_pin_o = r.pin[1];
	assign arm_pin_oe_o = r.pin_oe;

	always_comb
	begin
		logic [1:0][SAMPLE_W-1:0] smp;
		logic [1:0][THR_W-1:0] tp;
		logic [1:0][THR_W-1:0] tn;
		logic [1:0][1:0] win;
		logic [1:0][1:0] sts;
		logic [1:0] ev;
		logic cs_rise;
		logic cs_fall;
		logic sck_rise;
		logic sck_fall;
		logic ax;
		logic cnt_md;
		logic unf_md;
		logic pcm_md;
		logic low;
		logic hit;
		logic act;
		logic tick;
		logic [6:0] nsum;
		logic [CNT_W-1:0] c;
		logic signed [THR_W-1:0] s8;
		logic signed [SAMPLE_W-1:0] ss;
		logic [PCM_W-1:0] u9;
		logic [PCM_W:0] psum;

		smp[0] = x_sample_i;
		smp[1] = y_sample_i;
		tp[0] = x_arm_threshold_pos_i;
		tp[1] = y_arm_threshold_pos_i;
		tn[0] = x_arm_threshold_neg_i;
		tn[1] = y_arm_threshold_neg_i;
		win[0] = x_window_size_i;
		win[1] = y_window_size_i;
		sts[0] = x_stretch_setting_i;
		sts[1] = y_stretch_setting_i;
		ev = 2'h0;
		ax = 1'b0;
		hit = 1'b0;
		act = 1'b0;
		c = '0;
		s8 = '0;
		ss = '0;
		u9 = '0;
		psum = '0;
		fifo_push = 1'b0;
		fifo_word = r.sh_x;
		n = r;

		// Pins cross from the master's domain; first stage feeds second, and also the MISO enable for chip select
		n.csa_m = ~spi_cs_n_i;
		n.csa_s = r.csa_m;
		n.csa_d = r.csa_s;
		n.sclk_m = spi_sclk_i;
		n.sclk_s = r.sclk_m;
		n.sclk_d = r.sclk_s;
		n.mosi_m = spi_mosi_i;
		n.mosi_s = r.mosi_m;

		cs_fall = r.csa_s && !r.csa_d;
		cs_rise = !r.csa_s && r.csa_d;
		sck_rise = r.csa_s && r.sclk_s && !r.sclk_d;
		sck_fall = r.csa_s && !r.sclk_s && r.sclk_d;

		// Mode 0: capture on rising SCLK, advance MISO on falling
		if (sck_rise)
		begin
			n.sh_x = {r.sh_x[FRAME_W-2:0], r.mosi_s};
			n.sh_y = {r.sh_y[FRAME_W-2:0], r.mosi_s};
			if (r.bitcnt != 5'h1F)
				n.bitcnt = r.bitcnt + 5'h1;
		end
		if (sck_fall)
			n.tx = {r.tx[FRAME_W-2:0], 1'b0};

		if (cs_fall)
		begin
			n.bitcnt = '0;
			n.tx = r.next_word;
			n.tx_en = r.next_en;
			n.cur_acc = r.next_acc;
			n.next_en = 1'b0;
			n.next_acc = 2'h0;
		end

		if (cs_rise)
		begin
			n.tx_en = 1'b0;
			n.cur_acc = 2'h0;
			ax = r.sh_x[CMD_AX_BIT];
			if (r.bitcnt != FRAME_BITS || r.sh_x != r.sh_y)
			begin
				// Y stays quiet; only the X block's error word goes out
				n.next_word = ERR_WORD;
				n.next_en = 1'b1;
			end
			else if (r.sh_x[CMD_A_BIT])
			begin
				// Acceleration request routed to the block of its axis
				ev[ax] = 1'b1;
				n.next_word = {1'b0, ax, RESP_ACC_TAG, smp[ax]};
				n.next_en = 1'b1;
				n.next_acc[ax] = 1'b1;
			end
			else
			begin
				// Register op: any address goes to the one command FIFO; echoed, or error word if FIFO full
				fifo_push = 1'b1;
				if (fifo_in_ready)
					n.next_word = r.sh_x;
				else
					n.next_word = ERR_WORD;
				n.next_en = 1'b1;
			end
		end
		n.miso = n.tx[FRAME_W-1];
		n.miso_oe = n.tx_en && n.csa_s;

		cnt_md = arming_config_i == MODE_CNT_HI ||
			arming_config_i == MODE_CNT_LO;
		unf_md = arming_config_i == MODE_UNF_HI ||
			arming_config_i == MODE_UNF_LO;
		pcm_md = arming_config_i == MODE_PCM;
		low = arming_config_i[0];

		nsum = r.nco + PCM_NCO_STEP;
		tick = nsum >= PCM_NCO_MOD;
		n.nco = tick ? nsum - PCM_NCO_MOD : nsum;
		n.pin_oe = cnt_md || unf_md || pcm_md;

		for (int a = 0; a < 2; a++)
		begin
			if (r.str[a] != '0)
				n.str[a] = r.str[a] - 1'b1;
			s8 = $signed(smp[a][SAMPLE_W-1:SAMPLE_W-THR_W]);
			hit = s8 >= $signed(tp[a]) || s8 <= $signed(tn[a]);
			if (!(cnt_md || unf_md))
			begin
				// Disabling clears history so a new window starts clean
				n.cnt[a] = '0;
				n.cond[a] = 1'b0;
				n.str[a] = '0;
			end
			else if (ev[a] && !exception_i)
			begin
				if (cnt_md)
				begin
					if (hit)
						c = (r.cnt[a] == '1) ? r.cnt[a] : r.cnt[a] + 1'b1;
					else
						c = '0;
					n.cnt[a] = c;
					n.cond[a] = c >= WIN_LIMIT[win[a]];
					if (n.cond[a] && sts[a] != 2'h0)
						n.str[a] = STR_W'(STRETCH_UNIT_CYC_P * int'(sts[a]));
				end
				else
					n.cond[a] = hit;
			end

			if (cnt_md)
				act = (sts[a] == 2'h0) ? r.cond[a] : r.str[a] != '0;
			else
				act = r.cond[a] && r.csa_s && r.cur_acc[a];

			ss = $signed(smp[a]);
			if (ss > SAMPLE_W'(PCM_SMAX))
				u9 = PCM_W'(PCM_SMAX) ^ PCM_MID;
			else if (ss < SAMPLE_W'(PCM_SMIN))
				u9 = PCM_W'(PCM_SMIN) ^ PCM_MID;
			else
				u9 = ss[PCM_W-1:0] ^ PCM_MID;

			if (pcm_md)
			begin
				if (tick)
				begin
					psum = {1'b0, r.acc[a]} + {1'b0, u9};
					n.acc[a] = psum[PCM_W-1:0];
					n.pin[a] = psum[PCM_W];
				end
			end
			else
			begin
				n.acc[a] = '0;
				if (cnt_md || unf_md)
					n.pin[a] = act ^ low;
				else
					n.pin[a] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			r <= '0;
		else
			r <= n;
	end

	aap_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_cmd_fifo (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.in_data_i(fifo_word),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_in_ready),
		.out_data_o(reg_cmd_o),
		.out_valid_o(reg_cmd_valid_o),
		.out_ready_i(reg_cmd_ready_i)
	);
endmodule

// ==== sim/aap_properties.sv ====
/*
 Port-level checker for aap_top: arming pins, SPI drive and command FIFO.
 Assumes one clock domain and the reset of aap_top.
*/
module aap_checker #(
	parameter int STRETCH_UNIT_CYC_P = 20
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_oe_o,
	input wire logic [2:0] arming_config_i,
	input wire logic [1:0] x_stretch_setting_i,
	input wire logic x_arm_pin_o,
	input wire logic y_arm_pin_o,
	input wire logic arm_pin_oe_o,
	input wire logic [15:0] reg_cmd_o,
	input wire logic reg_cmd_valid_o,
	input wire logic reg_cmd_ready_i
);
	logic hold_w;
	int run_r;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Pin held by a one-unit stretch while no request is running
	assign hold_w = arming_config_i == 3'h2 && x_stretch_setting_i == 2'h1
		&& spi_cs_n_i && x_arm_pin_o;
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			run_r <= 0;
		else if (hold_w)
			run_r <= run_r + 1;
		else
			run_r <= 0;
	oe_mode_a: assert property ($stable(arming_config_i)[*3] |->
		arm_pin_oe_o == (arming_config_i inside {[3'h2:3'h6]}))
		else $error("pin enable does not follow mode");
	miso_idle_a: assert property (spi_cs_n_i[*8] |-> !spi_miso_oe_o)
		else $error("MISO driven while deselected");
	// The pin follows a polarity change one cycle late, so wait it out
	unf_pin_a: assert property ((arming_config_i inside {3'h4, 3'h5}
		&& spi_cs_n_i && $stable(arming_config_i))[*8]
		|-> x_arm_pin_o == (arming_config_i == 3'h5)
		&& y_arm_pin_o == (arming_config_i == 3'h5))
		else $error("unfiltered pin active outside frame");
	off_pin_a: assert property ((arming_config_i == 3'h0)[*3] |->
		!x_arm_pin_o && !y_arm_pin_o)
		else $error("pin active in off mode");
	count_still_a: assert property ((arming_config_i == 3'h2
		&& x_stretch_setting_i == 2'h0 && spi_cs_n_i)[*8]
		|=> $stable(x_arm_pin_o))
		else $error("count pin moved without a request");
	stretch_hold_a: assert property (arming_config_i == 3'h2
		&& x_stretch_setting_i == 2'h1 && $rose(x_arm_pin_o)
		|-> x_arm_pin_o[*8])
		else $error("stretched pin released early");
	stretch_end_a: assert property (run_r <= STRETCH_UNIT_CYC_P + 6)
		else $error("stretched pin outlived its timer");
	fifo_hold_a: assert property (reg_cmd_valid_o && !reg_cmd_ready_i
		|=> reg_cmd_valid_o && $stable(reg_cmd_o))
		else $error("command head lost while stalled");
endmodule

bind aap_top aap_checker #(.STRETCH_UNIT_CYC_P(STRETCH_UNIT_CYC_P)) u_chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_miso_oe_o(spi_miso_oe_o), .arming_config_i(arming_config_i),
	.x_stretch_setting_i(x_stretch_setting_i), .x_arm_pin_o(x_arm_pin_o),
	.y_arm_pin_o(y_arm_pin_o), .arm_pin_oe_o(arm_pin_oe_o),
	.reg_cmd_o(reg_cmd_o), .reg_cmd_valid_o(reg_cmd_valid_o),
	.reg_cmd_ready_i(reg_cmd_ready_i));

// ==== sim/aap_spi_master.sv ====
/*
 SPI master model standing in for the host controller.
 Assumes it is called just after a falling clk_i edge; paces SCLK by clk_i.
*/
module aap_spi_master (
	input wire logic clk_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Short frames (n below 16) are only for provoking a refusal
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = '0;
		cs_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			mosi_o = tx[i];
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			rx = {rx[14:0], miso_i};
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		// Idle MOSI must not look like held data
		mosi_o = ~mosi_o;
		repeat (8) @(negedge clk_i);
	endtask
endmodule

// ==== sim/test_accel_arming_pcm_output.sv ====
/*
 Self-checking bench for aap_top with a one-unit stretch of 20 cycles.
 Assumes aap_spi_master as host and the bound checker.
*/
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
	n_errors++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module test_accel_arming_pcm_output;
	timeunit 1ns;
	timeprecision 1ns;
	import aap_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, exc = 1'b0, rready = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, xpin, ypin, pin_oe, rvalid;
	logic [2:0] cfg = MODE_OFF;
	logic [7:0] xp = 8'h10, xn = 8'hF0, yp = 8'h10, yn = 8'hF0;
	logic [1:0] xw = 2'h1, yw = 2'h0, xs = 2'h0, ys = 2'h0;
	logic [11:0] xsmp = 12'h000, ysmp = 12'h000;
	logic [15:0] rx, rcmd;
	int n_errors = 0, n_checks = 0;
	always #5 clk = ~clk;
	aap_spi_master m (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
		.mosi_o(mosi), .miso_i(miso));
	aap_top #(.STRETCH_UNIT_CYC_P(20)) DUT (.clk_i(clk), .reset_n_i(reset_n),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
		.spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .arming_config_i(cfg),
		.x_arm_threshold_pos_i(xp), .x_arm_threshold_neg_i(xn),
		.y_arm_threshold_pos_i(yp), .y_arm_threshold_neg_i(yn),
		.x_window_size_i(xw), .y_window_size_i(yw),
		.x_stretch_setting_i(xs), .y_stretch_setting_i(ys),
		.exception_i(exc), .x_sample_i(xsmp), .y_sample_i(ysmp),
		.x_arm_pin_o(xpin), .y_arm_pin_o(ypin), .arm_pin_oe_o(pin_oe),
		.reg_cmd_o(rcmd), .reg_cmd_valid_o(rvalid), .reg_cmd_ready_i(rready));
	task automatic req(input logic [15:0] c);
		m.xfer(c, 16, rx);
	endtask
	task automatic t_count();
		cfg = MODE_CNT_HI;
		xsmp = 12'h100;
		req(16'h2000);
		`CHK("x pin", 1'b0, xpin)
		xsmp = 12'hF00;
		req(16'h2000);
		`CHK("x pin", 1'b1, xpin)
		`CHK("x reply", 16'h1100, rx)
		xsmp = 12'h0F0;
		req(16'h2000);
		`CHK("x pin", 1'b0, xpin)
		cfg = MODE_CNT_LO;
		repeat (4) @(negedge clk);
		`CHK("x pin low", 1'b1, xpin)
	endtask
	task automatic t_stretch();
		cfg = MODE_OFF;
		@(negedge clk);
		xw = 2'h0;
		xs = 2'h1;
		cfg = MODE_CNT_HI;
		xsmp = 12'h200;
		req(16'h2000);
		`CHK("x pin", 1'b1, xpin)
		repeat (20) @(negedge clk);
		`CHK("x pin", 1'b0, xpin)
		exc = 1'b1;
		req(16'h2000);
		`CHK("x pin", 1'b0, xpin)
		exc = 1'b0;
		req(16'h2000);
		`CHK("x pin", 1'b1, xpin)
		ys = 2'h2;
		ysmp = 12'h200;
		req(16'h6000);
		repeat (25) @(negedge clk);
		`CHK("x pin", 1'b0, xpin)
		`CHK("y pin", 1'b1, ypin)
	endtask
	task automatic t_unf();
		cfg = MODE_UNF_HI;
		req(16'h6000);
		`CHK("y pin", 1'b0, ypin)
		fork
			req(16'h6000);
			begin
				repeat (40) @(negedge clk);
				`CHK("y pin", 1'b1, ypin)
				`CHK("x pin", 1'b0, xpin)
			end
		join
		`CHK("y pin", 1'b0, ypin)
		cfg = MODE_UNF_LO;
		repeat (10) @(negedge clk);
		`CHK("y pin low", 1'b1, ypin)
	endtask
	task automatic t_pcm();
		logic [15:0] nx = '0, ny = '0;
		cfg = MODE_PCM;
		xsmp = 12'h800;
		ysmp = 12'h000;
		repeat (50) @(negedge clk);
		repeat (1300) @(negedge clk)
		begin
			nx = nx + xpin;
			ny = ny + ypin;
		end
		`CHK("pcm oe", 1'b1, pin_oe)
		`CHK("pcm x", 16'h0000, nx)
		`CHK("pcm y", 1'b1, ny inside {[600:700]})
	endtask
	task automatic t_fifo();
		for (int i = 0; i < 17; i++)
		begin
			req({3'b000, 5'(i), 8'h00});
			if (i > 0)
				`CHK("echo", {3'b000, 5'(i - 1), 8'h00}, rx)
		end
		req(16'h2000);
		`CHK("full", ERR_WORD, rx)
		m.xfer(16'h2000, 12, rx);
		req(16'h2000);
		`CHK("short", ERR_WORD, rx)
		rready = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			`CHK("head", {3'b000, 5'(i), 8'h00}, rcmd)
			@(negedge clk);
		end
		`CHK("empty", 1'b0, rvalid)
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		t_count();
		t_stretch();
		t_unf();
		t_pcm();
		t_fifo();
		print_verdict();
	end
endmodule
